// *** hw/wdtaux_top.sv ***
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - Timeout value zero disables counting expiry entirely.
// RULE2 - Timeout value is binary count of units, one to 255.
// RULE3 - Unit register top bit selects seconds when set, minutes when clear.
// RULE4 - Config bit 0 lets game port accesses restart the timer.
// RULE5 - Config bit 1 lets keyboard interrupts restart the timer.
// RULE6 - Config bit 2 lets mouse interrupts restart the timer.
// RULE7 - Config bits 7:4 pick the interrupt line; zero disables, two invalid.
// RULE8 - Control bit 0 reads one after timeout, zero while counting; here it stays one until software writes it to zero, even after a restart.
// RULE9 - Writing control bit 2 forces timeout and the bit self-clears.
// RULE10 - With control bit 3 set, controller line rising edge forces timeout.
// RULE11 - Line edge detector self-clears; pulse ORed with software force.
// RULE12 - Software writes zero to control upper four bits.
// RULE13 - Restart reloads counter; expiry sets status and raises mapped line.
module wdtaux_top #(
    parameter int unsigned SECOND_CYCLES = 32'(wdtaux_pkg::CYCLES_PER_SECOND)
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Restart sources, same clock domain
    input wire wdtaux_pkg::wdtaux_restart_t restart_src,
    // Keyboard controller force line, asynchronous pin
    input wire logic kbc_force_line,
    // Interrupt outputs
    output logic [15:0] irq_lines,
    output logic irq
);

    initial begin
        if (SECOND_CYCLES < 2) begin
            $error("wdtaux_top: SECOND_CYCLES must be at least 2");
        end
    end

    // ============================================================
    // Bus slave
    // ============================================================
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic [7:0] acc_idx;
    logic acc;
    logic wr_en;

    assign acc = hsel && hready && (htrans == wdtaux_pkg::HTRANS_NONSEQ);
    assign acc_idx = haddr[9:2];
    assign wr_en = wr_pend_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            wr_idx_q <= acc_idx;
        end
    end

    function automatic logic wr_hit(input logic [7:0] idx);
        return wr_en && (wr_idx_q == idx);
    endfunction : wr_hit

    // ============================================================
    // Registers
    // ============================================================
    logic [7:0] unit_q;
    logic [7:0] timeout_q;
    logic [7:0] config_q;
    logic [7:0] control_q;
    logic [7:0] irq_stat_q;
    logic [7:0] irq_mask_q;
    logic expire;
    logic force_event;
    logic [7:0] load_val;

    // A timeout write reloads at once, so the counter takes the byte being written.
    assign load_val = wr_hit(wdtaux_pkg::IDX_TIMEOUT_VALUE) ? hwdata[7:0] : timeout_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unit_q <= wdtaux_pkg::REG_RESET;
            timeout_q <= wdtaux_pkg::REG_RESET;
            config_q <= wdtaux_pkg::REG_RESET;
            irq_mask_q <= wdtaux_pkg::REG_RESET;
        end else begin
            if (wr_hit(wdtaux_pkg::IDX_UNIT_SELECT)) begin
                unit_q <= hwdata[7:0] & wdtaux_pkg::UNIT_WRITABLE;
            end
            if (wr_hit(wdtaux_pkg::IDX_TIMEOUT_VALUE)) begin
                timeout_q <= hwdata[7:0];
            end
            if (wr_hit(wdtaux_pkg::IDX_CONFIG)) begin
                config_q <= hwdata[7:0] & wdtaux_pkg::CFG_WRITABLE;
            end
            if (wr_hit(wdtaux_pkg::IDX_IRQ_MASK)) begin
                irq_mask_q <= hwdata[7:0] & wdtaux_pkg::IRQ_WRITABLE;
            end
        end
    end

    // Status sets on timeout and wins over a software write in the same cycle.
    // RULE8 status flag
    // RULE12 reserved bits dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control_q <= wdtaux_pkg::REG_RESET;
        end else begin
            if (wr_hit(wdtaux_pkg::IDX_CONTROL)) begin
                control_q <= hwdata[7:0] & wdtaux_pkg::CTRL_WRITABLE;
            end
            if (expire) begin
                control_q[wdtaux_pkg::CTRL_STATUS_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= wdtaux_pkg::REG_RESET;
        end else if (expire) begin
            irq_stat_q[wdtaux_pkg::IRQ_EXPIRY_BIT] <= 1'b1;
        end else if (wr_hit(wdtaux_pkg::IDX_IRQ_STATUS)) begin
            irq_stat_q <= irq_stat_q & ~(hwdata[7:0] & wdtaux_pkg::IRQ_WRITABLE);
        end
    end

    logic [15:0] rd_half;

    // A write in its data phase lands at the same edge as a read right behind it,
    // so that read is given the new contents rather than the old ones.
    function automatic logic [7:0] fwd(input logic [7:0] idx, input logic [7:0] cur,
        input logic [7:0] keep);
        return wr_hit(idx) ? (hwdata[7:0] & keep) : cur;
    endfunction : fwd

    always_comb begin
        rd_half = 16'h0000;
        unique case (acc_idx)
            wdtaux_pkg::IDX_UNIT_SELECT: begin
                rd_half = {8'h00, fwd(acc_idx, unit_q, wdtaux_pkg::UNIT_WRITABLE)};
            end
            wdtaux_pkg::IDX_TIMEOUT_VALUE: begin
                rd_half = {8'h00, load_val};
            end
            wdtaux_pkg::IDX_CONFIG: begin
                rd_half = {8'h00, fwd(acc_idx, config_q, wdtaux_pkg::CFG_WRITABLE)};
            end
            wdtaux_pkg::IDX_CONTROL: begin
                rd_half = {8'h00, fwd(acc_idx, control_q, wdtaux_pkg::CTRL_WRITABLE)
                    | (8'(expire) << wdtaux_pkg::CTRL_STATUS_BIT)};
            end
            wdtaux_pkg::IDX_IRQ_STATUS: begin
                rd_half = {8'h00, (8'(expire) << wdtaux_pkg::IRQ_EXPIRY_BIT) | (wr_hit(acc_idx)
                    ? irq_stat_q & ~(hwdata[7:0] & wdtaux_pkg::IRQ_WRITABLE) : irq_stat_q)};
            end
            wdtaux_pkg::IDX_IRQ_MASK: begin
                rd_half = {8'h00, fwd(acc_idx, irq_mask_q, wdtaux_pkg::IRQ_WRITABLE)};
            end
            wdtaux_pkg::IDX_IRQ_LINES: begin
                rd_half = irq_lines;
            end
            default: begin
                rd_half = 16'h0000;
            end
        endcase
    end

    // Read data is registered in the data phase; zero for unmapped indices.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (acc && !hwrite) begin
            hrdata <= {16'h0000, rd_half};
        end
    end

    // ============================================================
    // Force sources
    // ============================================================
    logic [2:0] kbc_sync_q;
    logic kbc_level_q;
    logic kbc_rise;
    logic sw_force;

    // The pin is asynchronous; a change counts once stages two and three agree.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kbc_sync_q <= 3'h0;
            kbc_level_q <= 1'b0;
        end else begin
            kbc_sync_q <= {kbc_sync_q[1:0], kbc_force_line};
            if (kbc_sync_q[1] == kbc_sync_q[2]) begin
                kbc_level_q <= kbc_sync_q[2];
            end
        end
    end

    // RULE11 edge detect
    // A line held high gives one pulse only, so it cannot pin the timer.
    assign kbc_rise = kbc_sync_q[1] && kbc_sync_q[2] && !kbc_level_q;

    // RULE9 force write
    // The force bit is never stored, so it reads zero and needs no clearing.
    assign sw_force = wr_hit(wdtaux_pkg::IDX_CONTROL) && hwdata[wdtaux_pkg::CTRL_FORCE_BIT];

    // RULE10 line enable
    // RULE11 ORed force
    assign force_event = sw_force || (kbc_rise && control_q[wdtaux_pkg::CTRL_KBC_EN_BIT]);

    // ============================================================
    // Countdown
    // ============================================================
    logic [7:0] count_q;
    logic running_q;
    logic restart;
    logic unit_tick;
    logic count_expire;

    // RULE4 game restart
    // RULE5 keyboard restart
    // RULE6 mouse restart
    // Writing the timeout value also reloads, so a new value acts at once.
    assign restart = (restart_src.game_access && config_q[wdtaux_pkg::CFG_GAME_BIT])
        || (restart_src.kbd_irq && config_q[wdtaux_pkg::CFG_KBD_BIT])
        || (restart_src.mouse_irq && config_q[wdtaux_pkg::CFG_MOUSE_BIT])
        || wr_hit(wdtaux_pkg::IDX_TIMEOUT_VALUE);

    // RULE3 unit select
    wdtaux_tick #(
        .SECOND_CYCLES(SECOND_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .restart(restart),
        .seconds(unit_q[wdtaux_pkg::UNIT_SECONDS_BIT]),
        .unit_tick(unit_tick)
    );

    // RULE1 zero disables
    // RULE2 binary units
    assign count_expire = running_q && unit_tick && (count_q == 8'h01)
        && (timeout_q != wdtaux_pkg::TIMEOUT_OFF);
    assign expire = count_expire || force_event;

    // RULE13 reload on restart
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= 8'h00;
            running_q <= 1'b0;
        end else if (restart) begin
            // A zero value never runs, so the counter cannot wrap below zero.
            count_q <= load_val;
            running_q <= (load_val != wdtaux_pkg::TIMEOUT_OFF);
        end else if (count_expire) begin
            count_q <= 8'h00;
            running_q <= 1'b0;
        end else if (running_q && unit_tick) begin
            count_q <= count_q - 8'h01;
        end
    end

    // ============================================================
    // Interrupt routing
    // ============================================================
    logic [3:0] map_sel;
    logic map_ok;

    assign map_sel = config_q[wdtaux_pkg::CFG_MAP_LSB +: 4];
    // RULE7 line mapping
    assign map_ok = (map_sel != wdtaux_pkg::MAP_DISABLE) && (map_sel != wdtaux_pkg::MAP_INVALID);

    // RULE13 mapped line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_lines <= 16'h0000;
        end else begin
            irq_lines <= 16'h0000;
            if (map_ok && control_q[wdtaux_pkg::CTRL_STATUS_BIT]) begin
                irq_lines[map_sel] <= 1'b1;
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ============================================================
    // Checks
    // ============================================================
    property p_zero_disable;
        @(posedge hclk) disable iff (!hresetn)
        (timeout_q == wdtaux_pkg::TIMEOUT_OFF) |-> !count_expire && (count_q == 8'h00)
            && !running_q;
    endproperty
    a_zero_disable: assert property (p_zero_disable) else $error("expiry with timeout zero"); // RULE1

    property p_count_down;
        @(posedge hclk) disable iff (!hresetn)
        (running_q && unit_tick && !restart && count_q > 8'h01) |=> (count_q == $past(count_q) - 8'h01);
    endproperty
    a_count_down: assert property (p_count_down) else $error("count did not step down"); // RULE2

    property p_game_off;
        @(posedge hclk) disable iff (!hresetn)
        (restart_src.game_access && !config_q[wdtaux_pkg::CFG_GAME_BIT] && !restart_src.kbd_irq
            && !restart_src.mouse_irq && !wr_en) |-> !restart;
    endproperty
    a_game_off: assert property (p_game_off) else $error("disabled game restart acted"); // RULE4

    property p_restart_load;
        @(posedge hclk) disable iff (!hresetn)
        (restart && !wr_en) |=> (count_q == timeout_q)
            && (running_q == (timeout_q != wdtaux_pkg::TIMEOUT_OFF));
    endproperty
    a_restart_load: assert property (p_restart_load) else $error("restart did not reload"); // RULE13

    property p_status_set;
        @(posedge hclk) disable iff (!hresetn)
        expire |=> control_q[wdtaux_pkg::CTRL_STATUS_BIT]
            ##1 (control_q[wdtaux_pkg::CTRL_STATUS_BIT] || $past(wr_en));
    endproperty
    a_status_set: assert property (p_status_set) else $error("status flag not set"); // RULE8

    property p_sw_force;
        @(posedge hclk) disable iff (!hresetn)
        sw_force |=> control_q[wdtaux_pkg::CTRL_STATUS_BIT] && !control_q[wdtaux_pkg::CTRL_FORCE_BIT];
    endproperty
    a_sw_force: assert property (p_sw_force) else $error("force write failed"); // RULE9

    property p_kbc_gate;
        @(posedge hclk) disable iff (!hresetn)
        (kbc_rise && !control_q[wdtaux_pkg::CTRL_KBC_EN_BIT] && !sw_force) |-> !force_event;
    endproperty
    a_kbc_gate: assert property (p_kbc_gate) else $error("disabled line forced timeout"); // RULE10

    property p_edge_once;
        @(posedge hclk) disable iff (!hresetn)
        kbc_rise |=> !kbc_rise;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge pulse repeated"); // RULE11

    property p_map_line;
        @(posedge hclk) disable iff (!hresetn)
        (map_ok && control_q[wdtaux_pkg::CTRL_STATUS_BIT]) |=> irq_lines[$past(map_sel)] || $changed(config_q);
    endproperty
    a_map_line: assert property (p_map_line) else $error("mapped line not raised"); // RULE7

    c_count_expire: cover property (@(posedge hclk) disable iff (!hresetn) count_expire);
    c_kbc_force: cover property (@(posedge hclk) disable iff (!hresetn) kbc_rise && force_event);
    c_sw_force: cover property (@(posedge hclk) disable iff (!hresetn) sw_force);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);

endmodule : wdtaux_top

// *** hw/wdtaux_pkg.sv ***
package wdtaux_pkg;

    // ============================================================
    // Register indices and byte addresses
    // ============================================================
    // Printed offsets are not multiples of four, so each one is an index
    // and its byte address is four times the index.
    localparam logic [7:0] IDX_UNIT_SELECT = 8'hF1;
    localparam logic [7:0] IDX_TIMEOUT_VALUE = 8'hF2;
    localparam logic [7:0] IDX_CONFIG = 8'hF3;
    localparam logic [7:0] IDX_CONTROL = 8'hF4;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hF5;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hF6;
    localparam logic [7:0] IDX_IRQ_LINES = 8'hF7;

    // ============================================================
    // Field positions and reset values
    // ============================================================
    localparam int UNIT_SECONDS_BIT = 7;
    localparam int CFG_GAME_BIT = 0;
    localparam int CFG_KBD_BIT = 1;
    localparam int CFG_MOUSE_BIT = 2;
    localparam int CFG_MAP_LSB = 4;
    localparam int CTRL_STATUS_BIT = 0;
    localparam int CTRL_FORCE_BIT = 2;
    localparam int CTRL_KBC_EN_BIT = 3;
    localparam logic [3:0] MAP_DISABLE = 4'h0;
    localparam logic [3:0] MAP_INVALID = 4'h2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] TIMEOUT_OFF = 8'h00;
    localparam logic [7:0] CTRL_WRITABLE = 8'h09;
    localparam logic [7:0] UNIT_WRITABLE = 8'h80;
    localparam logic [7:0] CFG_WRITABLE = 8'hF7;

    // Interrupt status layout: bit 0 is the expiry event.
    localparam int IRQ_EXPIRY_BIT = 0;
    localparam logic [7:0] IRQ_WRITABLE = 8'h01;

    // ============================================================
    // Bus encodings and timing
    // ============================================================
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int SECONDS_PER_MINUTE = 60;
    localparam int CLOCK_MHZ = 250;
    localparam longint CYCLES_PER_SECOND = longint'(CLOCK_MHZ) * 1000000;

    typedef struct packed {
        logic game_access;
        logic kbd_irq;
        logic mouse_irq;
    } wdtaux_restart_t;

endpackage : wdtaux_pkg

// *** hw/wdtaux_tick.sv ***
`timescale 1ns/1ps
// Divides the clock into a one-cycle enable once per time unit.
module wdtaux_tick #(
    parameter int unsigned SECOND_CYCLES = 32'(wdtaux_pkg::CYCLES_PER_SECOND)
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Unit control
    input wire logic restart,
    input wire logic seconds,
    output logic unit_tick
);

    initial begin
        if (SECOND_CYCLES < 2) begin
            $error("wdtaux_tick: SECOND_CYCLES must be at least 2");
        end
    end

    logic [31:0] cyc_q;
    logic [5:0] sec_q;
    logic sec_end;
    logic min_end;

    assign sec_end = (cyc_q == SECOND_CYCLES - 1);
    assign min_end = (sec_q == 6'(wdtaux_pkg::SECONDS_PER_MINUTE - 1));

    // Restart realigns the unit so a fresh count gets a whole first unit.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cyc_q <= 32'h0000_0000;
        end else if (restart || sec_end) begin
            cyc_q <= 32'h0000_0000;
        end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sec_q <= 6'h00;
        end else if (restart || (sec_end && min_end)) begin
            sec_q <= 6'h00;
        end else if (sec_end) begin
            sec_q <= sec_q + 6'h01;
        end
    end

    assign unit_tick = !restart && sec_end && (seconds || min_end);

endmodule : wdtaux_tick

// *** verification/tb_wdtaux_top.sv ***
`timescale 1ns/1ps
module tb_wdtaux_top;
    // ============================================================
    // Signals and design instance
    // ============================================================
    // A short second keeps minute-unit expiries inside the run budget.
    localparam int SEC = 10;
    logic hclk, hresetn, hsel, hwrite, hresp, hreadyout, irq, kbc_force_line;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] irq_lines;
    wdtaux_pkg::wdtaux_restart_t restart_src;
    int bad_count, checks_done, n;
    int vals[4];
    logic secs[4];

    wdtaux_top #(.SECOND_CYCLES(SEC)) wdtaux_top_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .restart_src(restart_src),
        .kbc_force_line(kbc_force_line), .irq_lines(irq_lines), .irq(irq)
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // ============================================================
    // Expectations and comparisons
    // ============================================================
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    function automatic int exp_cycles(input logic sec, input int val);
        return val * (sec ? SEC : SEC * 60);
    endfunction : exp_cycles

    function automatic logic [15:0] exp_line(input logic [3:0] m);
        if (m == wdtaux_pkg::MAP_DISABLE || m == wdtaux_pkg::MAP_INVALID) begin
            return 16'h0000;
        end
        return 16'h0001 << m;
    endfunction : exp_line

    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checks_done++;
        if (got !== e) begin
            bad_count++;
            $display("Error at %0t: value %h, expected %h", $time, got, e);
        end
    endtask : chk

    task automatic chk_range(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("Error at %0t: %0d cycles, expected %0d to %0d", $time, got, lo, hi);
        end
    endtask : chk_range

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // ============================================================
    // Bus master
    // ============================================================
    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            bad_count++;
            $display("Error at %0t: bus wait ran out", $time);
            wrap_up();
        end
    endtask : wait_ready

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= wdtaux_pkg::HTRANS_NONSEQ;
        hsize <= wdtaux_pkg::HSIZE_WORD;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, 32'(d));
    endtask : wr

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] e);
        xfer(1'b0, idx, 32'h0000_0000);
        chk(rd, e);
    endtask : rdchk

    // Counts cycles until a mapped line rises, giving up at the limit.
    // Lines are looked at on the falling edge, where they have settled.
    task automatic wait_irq(input int lim, output int c);
        c = 0;
        while (irq_lines === 16'h0000 && c < lim) begin
            @(negedge hclk);
            c++;
        end
        @(posedge hclk);
    endtask : wait_irq

    // Value is written last because that write reloads and starts the count.
    task automatic start(input logic sec, input logic [7:0] val, input logic [7:0] cfg);
        wr(wdtaux_pkg::IDX_CONFIG, cfg);
        wr(wdtaux_pkg::IDX_CONTROL, 8'h00);
        wr(wdtaux_pkg::IDX_IRQ_STATUS, 8'h01);
        wr(wdtaux_pkg::IDX_UNIT_SELECT, {sec, 7'h0});
        wr(wdtaux_pkg::IDX_TIMEOUT_VALUE, val);
    endtask : start

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = wdtaux_pkg::HSIZE_WORD;
        hwdata = 32'h0000_0000;
        restart_src = '0;
        kbc_force_line = 1'b0;
        seed = 32'h0000_0058;
        bad_count = 0;
        checks_done = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 1; i < 8; i++) begin
            rdchk(8'(8'hF0 + i), 32'h0000_0000);
        end
        rdchk(8'h10, 32'h0000_0000);
        chk(32'(hresp), 32'h0000_0000);
        repeat (4) begin
            seed = xs(seed);
            wr(wdtaux_pkg::IDX_UNIT_SELECT, seed[7:0]);
            rdchk(wdtaux_pkg::IDX_UNIT_SELECT, 32'(seed[7:0] & wdtaux_pkg::UNIT_WRITABLE));
            wr(wdtaux_pkg::IDX_CONFIG, seed[15:8]);
            rdchk(wdtaux_pkg::IDX_CONFIG, 32'(seed[15:8] & wdtaux_pkg::CFG_WRITABLE));
            wr(wdtaux_pkg::IDX_IRQ_MASK, seed[23:16]);
            rdchk(wdtaux_pkg::IDX_IRQ_MASK, 32'(seed[23:16] & wdtaux_pkg::IRQ_WRITABLE));
            wr(8'h10, seed[31:24]);
            rdchk(8'h10, 32'h0000_0000);
        end
        wr(wdtaux_pkg::IDX_IRQ_MASK, 8'h00);
        start(1'b1, wdtaux_pkg::TIMEOUT_OFF, 8'h50);
        rdchk(wdtaux_pkg::IDX_CONTROL, 32'h0000_0000);
        wait_irq(300, n);
        chk_range(n, 300, 300);
        seed = xs(seed);
        vals = '{1, 255, 2 + int'(seed[4:0]), 1};
        secs = '{1'b1, 1'b1, 1'b1, 1'b0};
        for (int k = 0; k < 4; k++) begin
            start(secs[k], 8'(vals[k]), 8'h50);
            wait_irq(exp_cycles(secs[k], vals[k]) + 20, n);
            chk_range(n, exp_cycles(secs[k], vals[k]) - 2, exp_cycles(secs[k], vals[k]) + 5);
            chk(32'(irq_lines), 32'h0000_0020);
            rdchk(wdtaux_pkg::IDX_CONTROL, 32'h0000_0001);
        end
        for (int i = 0; i < 3; i++) begin
            for (int en = 0; en < 2; en++) begin
                start(1'b1, 8'h03, 8'h50 | (en == 1 ? 8'(1 << i) : 8'(7 & ~(1 << i))));
                repeat (18) @(posedge hclk);
                rdchk(wdtaux_pkg::IDX_CONTROL, 32'h0000_0000);
                restart_src <= 3'(4 >> i);
                @(posedge hclk);
                restart_src <= '0;
                wait_irq(100, n);
                chk_range(n, en == 1 ? 28 : 7, en == 1 ? 36 : 15);
            end
        end
        wr(wdtaux_pkg::IDX_TIMEOUT_VALUE, 8'h00);
        for (int m = 0; m < 16; m++) begin
            wr(wdtaux_pkg::IDX_CONFIG, {4'(m), 4'h0});
            wr(wdtaux_pkg::IDX_CONTROL, 8'h00);
            wr(wdtaux_pkg::IDX_CONTROL, 8'h04);
            repeat (3) @(posedge hclk);
            chk(32'(irq_lines), 32'(exp_line(4'(m))));
            rdchk(wdtaux_pkg::IDX_CONTROL, 32'h0000_0001);
            if (m == 5) begin
                rdchk(wdtaux_pkg::IDX_IRQ_LINES, 32'h0000_0020);
            end
        end
        wr(wdtaux_pkg::IDX_CONTROL, 8'h00);
        repeat (3) @(posedge hclk);
        chk(32'(irq_lines), 32'h0000_0000);
        rdchk(wdtaux_pkg::IDX_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0000);
        wr(wdtaux_pkg::IDX_IRQ_MASK, 8'h01);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0001);
        wr(wdtaux_pkg::IDX_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'h0000_0000);
        rdchk(wdtaux_pkg::IDX_IRQ_STATUS, 32'h0000_0000);
        wr(wdtaux_pkg::IDX_CONFIG, 8'h50);
        kbc_force_line <= 1'b1;
        repeat (10) @(posedge hclk);
        chk(32'(irq_lines), 32'h0000_0000);
        kbc_force_line <= 1'b0;
        wr(wdtaux_pkg::IDX_CONTROL, 8'h08);
        for (int r = 0; r < 2; r++) begin
            kbc_force_line <= 1'b1;
            wait_irq(20, n);
            chk_range(n, 2, 10);
            wr(wdtaux_pkg::IDX_CONTROL, 8'h08);
            repeat (20) @(posedge hclk);
            chk(32'(irq_lines), 32'h0000_0000);
            rdchk(wdtaux_pkg::IDX_CONTROL, 32'h0000_0008);
            kbc_force_line <= 1'b0;
            repeat (5) @(posedge hclk);
        end
        wrap_up();
    end
endmodule : tb_wdtaux_top
